// ---- core/float_sign_pkg.sv ----
// Constants for the float pulse sign control register bank.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
`default_nettype none
package float_sign_pkg;
  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] MATH_CFG_IDX = 8'h58;
  localparam logic [7:0] ENABLE_CFG_IDX = 8'h59;
  localparam logic [9:0] MATH_CFG_ADDR = {MATH_CFG_IDX, 2'b00};
  localparam logic [9:0] ENABLE_CFG_ADDR = {ENABLE_CFG_IDX, 2'b00};
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MATH34_B_LSB = 10;
  localparam int MATH34_A_LSB = 8;
  localparam int INT_BUF_BIT = 7;
  localparam int MATH12_B_LSB = 5;
  localparam int MATH12_A_LSB = 1;
  localparam int FLOAT_EN_LSB = 13;
  localparam int PRECON_LSB = 8;
  localparam int RSVD_LOW_LSB = 0;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] SIGN_CODE_RESET = 2'h0;
  localparam logic [1:0] FLOAT_EN_RESET = 2'h0;
  localparam logic [4:0] PRECON_RESET = 5'h08;
  localparam logic [7:0] RSVD_LOW_VALUE = 8'h08;
  // ----------------------------------------------------------------
  // Float enable codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FLOAT_OFF = 2'b00,
    FLOAT_RSVD1 = 2'b01,
    FLOAT_RSVD2 = 2'b10,
    FLOAT_ON = 2'b11
  } float_en_e;
endpackage
`default_nettype wire

// ---- core/pair_sign_decode.sv ----
// Sign decode for one sample of an add/subtract pair.
// Assumes code bit 1 governs the earlier sample and bit 0 the later one.
`default_nettype none
module pair_sign_decode (
  // Pair code and position
  input wire logic [1:0] code_in,
  input wire logic later_in,
  // Sign
  output logic subtract_out
);
  // 00 add both, 01 subtract later, 10 subtract earlier, 11 subtract both
  assign subtract_out = later_in ? code_in[0] : code_in[1];
endmodule
`default_nettype wire

// ---- core/float_pulse_sign_control.sv ----
// Float pulse sign control: register bank and per-sample sign selection.
// Assumes a classic Wishbone master on clk_in and sample strobes on the same clock.
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none
// Function
// - Slot A third and fourth samples of each group of four are added or subtracted by code.
// - The integrator buffer bit turns the integrator into a buffer in transimpedance mode.
// - Slot B first and second samples of each group of four are signed by the field at 6:5.
// - Slot A first and second samples of each group of four are signed by the field at 2:1.
// - The slot B float field at 14:13 disables float at 0 and enables it at 3.
// - The five-bit field at 12:8 sets the slot B preconditioning delay, resetting to 8.
module float_pulse_sign_control (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Sample stream
  input wire logic sample_valid_in,
  input wire logic slot_b_in,
  input wire logic [1:0] pulse_pos_in,
  input wire logic tia_mode_in,
  output logic sample_valid_out,
  output logic sample_subtract_out,
  // Analog controls
  output logic integrator_buffer_out,
  output logic float_active_slot_b_out,
  output logic [4:0] float_precondition_slot_b_out
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] third_fourth_sign_slot_b_q, third_fourth_sign_slot_b_d;
  logic [1:0] third_fourth_sign_slot_a_q, third_fourth_sign_slot_a_d;
  logic integrator_buffer_enable_q, integrator_buffer_enable_d;
  logic [1:0] first_second_sign_slot_b_q, first_second_sign_slot_b_d;
  logic [1:0] first_second_sign_slot_a_q, first_second_sign_slot_a_d;
  logic [1:0] float_enable_slot_b_q, float_enable_slot_b_d;
  logic [4:0] float_precondition_slot_b_q, float_precondition_slot_b_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic req;
  logic [15:0] math_word;
  logic [15:0] enable_word;

  assign req = wb_cyc_in && wb_stb_in && !ack_q;
  assign math_word = {4'h0, third_fourth_sign_slot_b_q, third_fourth_sign_slot_a_q,
                      integrator_buffer_enable_q, first_second_sign_slot_b_q, 2'h0,
                      first_second_sign_slot_a_q, 1'b0};
  assign enable_word = {1'b0, float_enable_slot_b_q, float_precondition_slot_b_q,
                        float_sign_pkg::RSVD_LOW_VALUE};

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  always_comb begin
    third_fourth_sign_slot_b_d = third_fourth_sign_slot_b_q;
    third_fourth_sign_slot_a_d = third_fourth_sign_slot_a_q;
    integrator_buffer_enable_d = integrator_buffer_enable_q;
    first_second_sign_slot_b_d = first_second_sign_slot_b_q;
    first_second_sign_slot_a_d = first_second_sign_slot_a_q;
    float_enable_slot_b_d = float_enable_slot_b_q;
    float_precondition_slot_b_d = float_precondition_slot_b_q;
    ack_d = req;
    rdata_d = rdata_q;
    if (req && wb_adr_in == float_sign_pkg::MATH_CFG_ADDR) begin
      rdata_d = {16'h0000, math_word};
      if (wb_we_in && wb_sel_in[1]) begin
        third_fourth_sign_slot_b_d = wb_dat_in[float_sign_pkg::MATH34_B_LSB +: 2];
        third_fourth_sign_slot_a_d = wb_dat_in[float_sign_pkg::MATH34_A_LSB +: 2];
      end
      if (wb_we_in && wb_sel_in[0]) begin
        integrator_buffer_enable_d = wb_dat_in[float_sign_pkg::INT_BUF_BIT];
        first_second_sign_slot_b_d = wb_dat_in[float_sign_pkg::MATH12_B_LSB +: 2];
        first_second_sign_slot_a_d = wb_dat_in[float_sign_pkg::MATH12_A_LSB +: 2];
      end
    end else if (req && wb_adr_in == float_sign_pkg::ENABLE_CFG_ADDR) begin
      rdata_d = {16'h0000, enable_word};
      if (wb_we_in && wb_sel_in[1]) begin
        float_enable_slot_b_d = wb_dat_in[float_sign_pkg::FLOAT_EN_LSB +: 2];
        float_precondition_slot_b_d = wb_dat_in[float_sign_pkg::PRECON_LSB +: 5];
      end
    end else if (req) begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      third_fourth_sign_slot_b_q <= float_sign_pkg::SIGN_CODE_RESET;
      third_fourth_sign_slot_a_q <= float_sign_pkg::SIGN_CODE_RESET;
      integrator_buffer_enable_q <= 1'b0;
      first_second_sign_slot_b_q <= float_sign_pkg::SIGN_CODE_RESET;
      first_second_sign_slot_a_q <= float_sign_pkg::SIGN_CODE_RESET;
      float_enable_slot_b_q <= float_sign_pkg::FLOAT_EN_RESET;
      float_precondition_slot_b_q <= float_sign_pkg::PRECON_RESET;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      third_fourth_sign_slot_b_q <= third_fourth_sign_slot_b_d;
      third_fourth_sign_slot_a_q <= third_fourth_sign_slot_a_d;
      integrator_buffer_enable_q <= integrator_buffer_enable_d;
      first_second_sign_slot_b_q <= first_second_sign_slot_b_d;
      first_second_sign_slot_a_q <= first_second_sign_slot_a_d;
      float_enable_slot_b_q <= float_enable_slot_b_d;
      float_precondition_slot_b_q <= float_precondition_slot_b_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;

  // ----------------------------------------------------------------
  // Sample sign selection
  // ----------------------------------------------------------------
  logic [1:0] pair_code;
  logic pair_subtract;
  logic subtract_q, subtract_d;
  logic valid_q, valid_d;
  logic int_buf_q, int_buf_d;
  logic float_on_q, float_on_d;

  always_comb begin
    if (pulse_pos_in[1]) begin
      pair_code = slot_b_in ? third_fourth_sign_slot_b_q : third_fourth_sign_slot_a_q;
    end else begin
      pair_code = slot_b_in ? first_second_sign_slot_b_q : first_second_sign_slot_a_q;
    end
  end

  pair_sign_decode u_pair_sign_decode (
    .code_in(pair_code),
    .later_in(pulse_pos_in[0]),
    .subtract_out(pair_subtract)
  );

  always_comb begin
    valid_d = sample_valid_in;
    subtract_d = sample_valid_in ? pair_subtract : subtract_q;
    int_buf_d = integrator_buffer_enable_q && tia_mode_in;
    float_on_d = float_enable_slot_b_q == float_sign_pkg::FLOAT_ON;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      valid_q <= 1'b0;
      subtract_q <= 1'b0;
      int_buf_q <= 1'b0;
      float_on_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      subtract_q <= subtract_d;
      int_buf_q <= int_buf_d;
      float_on_q <= float_on_d;
    end
  end

  assign sample_valid_out = valid_q;
  assign sample_subtract_out = subtract_q;
  assign integrator_buffer_out = int_buf_q;
  assign float_active_slot_b_out = float_on_q;
  assign float_precondition_slot_b_out = float_precondition_slot_b_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write_math;
    req && wb_we_in && wb_adr_in == float_sign_pkg::MATH_CFG_ADDR && wb_sel_in[0];
  endsequence
  sequence s_write_enable;
    req && wb_we_in && wb_adr_in == float_sign_pkg::ENABLE_CFG_ADDR && wb_sel_in[1];
  endsequence

  a_slot_a_late_pair: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sample_valid_in && !slot_b_in && pulse_pos_in[1] |=>
      sample_subtract_out == $past(third_fourth_sign_slot_a_q[~pulse_pos_in[0]]))
    else $error("slot A third/fourth sign wrong");
  a_integrator_buffer_mode: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write_math ##1 tia_mode_in |=> integrator_buffer_out == $past(wb_dat_in[7], 2))
    else $error("integrator buffer control wrong");
  a_slot_b_early_pair: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sample_valid_in && slot_b_in && !pulse_pos_in[1] |=>
      sample_subtract_out == $past(first_second_sign_slot_b_q[~pulse_pos_in[0]]))
    else $error("slot B first/second sign wrong");
  a_slot_a_early_pair: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sample_valid_in && !slot_b_in && !pulse_pos_in[1] |=>
      sample_subtract_out == $past(first_second_sign_slot_a_q[~pulse_pos_in[0]]))
    else $error("slot A first/second sign wrong");
  a_slot_b_late_pair: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sample_valid_in && slot_b_in && pulse_pos_in[1] |=>
      sample_subtract_out == $past(third_fourth_sign_slot_b_q[~pulse_pos_in[0]]))
    else $error("slot B third/fourth sign wrong");
  a_precondition_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_write_enable |=> float_precondition_slot_b_out == $past(wb_dat_in[12:8]))
    else $error("preconditioning delay not written");
  a_read_upper_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wb_ack_out |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_valid_echo: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    sample_valid_in |=> sample_valid_out)
    else $error("sample valid not echoed");
  a_float_enable_on: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    float_enable_slot_b_q == float_sign_pkg::FLOAT_ON |=> float_active_slot_b_out)
    else $error("float mode not enabled at code 3");
  a_precondition_reset: assert property (@(posedge clk_in)
    $rose(reset_n_in) |-> float_precondition_slot_b_out == float_sign_pkg::PRECON_RESET)
    else $error("preconditioning delay not at reset value");
  a_float_reserved_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    float_enable_slot_b_q != float_sign_pkg::FLOAT_ON |=> !float_active_slot_b_out)
    else $error("reserved float code enabled float");
  a_bus_ack_once: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    req |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle");
endmodule
`default_nettype wire

// ---- sim/test_float_pulse_sign_control.sv ----
// Self-checking testbench for the float pulse sign control register bank.
// Assumes a one-cycle registered Wishbone ack and registered sample outputs.
`default_nettype none
module test_float_pulse_sign_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0, reset_n_in = 1'b0;
  logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [9:0] wb_adr_in = 10'h000;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
  logic wb_ack_out, sample_valid_in = 1'b0, slot_b_in = 1'b0, tia_mode_in = 1'b0;
  logic [1:0] pulse_pos_in = 2'h0;
  logic sample_valid_out, sample_subtract_out, integrator_buffer_out, float_active_slot_b_out;
  logic [4:0] float_precondition_slot_b_out;
  logic [31:0] seed = 32'hE561;
  int n_fail = 0, tests_run = 0;
  always #2 clk_in = ~clk_in;
  float_pulse_sign_control DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .sample_valid_in(sample_valid_in), .slot_b_in(slot_b_in),
    .pulse_pos_in(pulse_pos_in), .tia_mode_in(tia_mode_in),
    .sample_valid_out(sample_valid_out), .sample_subtract_out(sample_subtract_out),
    .integrator_buffer_out(integrator_buffer_out),
    .float_active_slot_b_out(float_active_slot_b_out),
    .float_precondition_slot_b_out(float_precondition_slot_b_out));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected sign: code bit 1 signs the earlier sample of the pair
  function automatic logic exp_sub(input logic [15:0] m, input logic slot, input logic [1:0] pos);
    logic [1:0] c;
    case ({slot, pos[1]})
      2'b00: c = m[2:1];
      2'b01: c = m[9:8];
      2'b10: c = m[6:5];
      default: c = m[11:10];
    endcase
    return pos[0] ? c[0] : c[1];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd, input logic [3:0] sel = 4'hF);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= wd;
    // Ack and read data are taken as sampled at the edge itself
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1) check(32'h1, 32'h0);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic sample(input logic slot, input logic [1:0] pos, input logic exp);
    @(posedge clk_in);
    sample_valid_in <= 1'b1;
    slot_b_in <= slot;
    pulse_pos_in <= pos;
    @(posedge clk_in);
    sample_valid_in <= 1'b0;
    #1;
    check({31'h0, sample_valid_out}, 32'h1);
    check({31'h0, sample_subtract_out}, {31'h0, exp});
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, m;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wb_xfer(1'b0, float_sign_pkg::MATH_CFG_ADDR, 32'h0, r);
    check(r, 32'h0);
    wb_xfer(1'b0, float_sign_pkg::ENABLE_CFG_ADDR, 32'h0, r);
    check(r, 32'h0808);
    check({27'h0, float_precondition_slot_b_out}, 32'h8);
    wb_xfer(1'b1, 10'h3F0, 32'hFFFF, r);
    wb_xfer(1'b0, 10'h3F0, 32'h0, r);
    check(r, 32'h0);
    $display("test reset and unmapped done");
    for (int i = 0; i < 12; i++) begin
      m = next_rand();
      // First four passes sweep every sign code in all fields
      if (i < 4) m = {20'h0, i[1:0], i[1:0], 1'b1, i[1:0], 2'b00, i[1:0], 1'b0};
      wb_xfer(1'b1, float_sign_pkg::MATH_CFG_ADDR, m, r);
      wb_xfer(1'b0, float_sign_pkg::MATH_CFG_ADDR, 32'h0, r);
      check(r, m & 32'h0FE6);
      for (int p = 0; p < 8; p++) sample(p[2], p[1:0], exp_sub(m[15:0], p[2], p[1:0]));
      @(posedge clk_in);
      tia_mode_in <= m[20];
      repeat (2) @(posedge clk_in);
      #1;
      check({31'h0, integrator_buffer_out}, {31'h0, m[7] & m[20]});
    end
    $display("test sign codes and integrator buffer done");
    // Byte lanes: only the enabled byte of the math word may change
    wb_xfer(1'b1, float_sign_pkg::MATH_CFG_ADDR, 32'h0FE6, r, 4'h2);
    wb_xfer(1'b0, float_sign_pkg::MATH_CFG_ADDR, 32'h0, r);
    check(r, (m & 32'h00E6) | 32'h0F00);
    wb_xfer(1'b1, float_sign_pkg::MATH_CFG_ADDR, 32'h0000, r, 4'h1);
    wb_xfer(1'b0, float_sign_pkg::MATH_CFG_ADDR, 32'h0, r);
    check(r, 32'h0F00);
    $display("test byte lanes done");
    for (int c = 0; c < 4; c++) begin
      m = next_rand();
      m = {17'h0, c[1:0], m[4:0], 8'h08};
      wb_xfer(1'b1, float_sign_pkg::ENABLE_CFG_ADDR, m | 32'hFFFF8000, r);
      wb_xfer(1'b0, float_sign_pkg::ENABLE_CFG_ADDR, 32'h0, r);
      check(r, m);
      check({31'h0, float_active_slot_b_out}, {31'h0, c == 3});
      check({27'h0, float_precondition_slot_b_out}, {27'h0, m[12:8]});
    end
    $display("test float enable codes done");
    // Reset in mid-run, with float left enabled by the last pass
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wb_xfer(1'b0, float_sign_pkg::ENABLE_CFG_ADDR, 32'h0, r);
    check(r, 32'h0808);
    check({31'h0, float_active_slot_b_out}, 32'h0);
    check({27'h0, float_precondition_slot_b_out}, 32'h8);
    $display("test mid-run reset done");
    finish_test();
  end
  initial begin
    #20000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
